/* verilog/ssc_exec.v */
// Execution unit for the conditional-skip and system-control instructions.
// Assumes a decoder on the same clock that presents one decoded instruction
// per cycle with its operands, and a stack memory that shows the word at
// stack_pointer minus two on stack_rdata_i.
//
// Added by the designer: the address map and the strobed register port.
`include "ssc_defs.vh"

// Overview of operation
// - Compare-equal memory: skip on match, subtract flags.
// - Compare-not-equal memory: skip on mismatch, flags.
// - Compare-not-equal immediate: skip on mismatch.
// - Test bit low: skip, flags unchanged.
// - Test bit high: skip, flags unchanged.
// - Increment, write back, skip on zero.
// - Decrement, write back, skip on zero.
// - Call pushes return address, jumps, stack plus two.
// - Goto loads target, two cycles, no flags.
// - Return immediate loads accumulator then returns.
// - Return pops stack by two into counter.
// - Interrupt return resumes and sets global enable.
// - No-operation takes one cycle, changes nothing.
// - Computed jump adds accumulator to counter.
// - Interrupt enable lets requests through.
// - Interrupt disable blocks requests.
// - Full halt stops clocks and oscillators.
// - Execution halt stops clocks, oscillators keep running.
// - Software reset resets the whole chip.
// - Watchdog clear restarts the watchdog count.
// - Compare-equal immediate: skip on match.
module ssc_exec #(
  parameter PCW = 12
) (
  // Clock and reset.
  input wire clock_i,
  input wire rstn_i,
  // Register port.
  input wire [`SSC_REG_AW-1:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_we_i,
  input wire reg_re_i,
  output reg [7:0] reg_rdata_o,
  // Decoded instruction and operands.
  input wire instr_valid_i,
  input wire [`SSC_OP_W-1:0] instr_op_i,
  input wire [7:0] operand_i,
  input wire [7:0] acc_i,
  input wire [7:0] imm_i,
  input wire [2:0] bit_sel_i,
  input wire [PCW-1:0] target_i,
  input wire [PCW-1:0] stack_rdata_i,
  input wire wake_i,
  // Program flow.
  output reg [PCW-1:0] program_counter_o,
  output reg [7:0] stack_pointer_o,
  output reg stack_we_o,
  output reg [7:0] stack_addr_o,
  output reg [PCW-1:0] stack_wdata_o,
  output reg bubble_o,
  // Data results.
  output reg acc_we_o,
  output reg [7:0] acc_wdata_o,
  output reg mem_we_o,
  output reg [7:0] mem_wdata_o,
  output reg flag_we_o,
  output reg zero_flag_o,
  output reg carry_flag_o,
  output reg auxiliary_carry_flag_o,
  output reg overflow_flag_o,
  // System control.
  output reg gie_o,
  output reg clk_stop_o,
  output reg osc_stop_o,
  output reg chip_reset_o,
  output reg wdt_clear_o
);

  // Squash states for the instruction after a skip or a jump.
  localparam SQ_NONE = 2'b00;
  localparam SQ_SKIP = 2'b01;
  localparam SQ_FLUSH = 2'b10;

  // Subtraction a - b: {overflow, aux borrow, borrow, zero, result}.
  function [11:0] sub_flags;
    input [7:0] a;
    input [7:0] b;
    reg [8:0] d;
    reg [4:0] h;
    begin
      d = {1'b0, a} - {1'b0, b};
      h = {1'b0, a[3:0]} - {1'b0, b[3:0]};
      sub_flags = {(a[7] ^ b[7]) & (a[7] ^ d[7]), h[4], d[8], d[7:0] == 8'h00, d[7:0]};
    end
  endfunction

  // Addition a + b: {overflow, aux carry, carry, zero, result}.
  function [11:0] add_flags;
    input [7:0] a;
    input [7:0] b;
    reg [8:0] s;
    reg [4:0] h;
    begin
      s = {1'b0, a} + {1'b0, b};
      h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
      add_flags = {~(a[7] ^ b[7]) & (a[7] ^ s[7]), h[4], s[8], s[7:0] == 8'h00, s[7:0]};
    end
  endfunction

  reg [PCW-1:0] pc_ff;
  reg [PCW-1:0] nxt_pc;
  reg [7:0] stk_ff;
  reg [7:0] nxt_stk;
  reg [1:0] sq_ff;
  reg [1:0] nxt_sq;
  reg gie_ff;
  reg nxt_gie;
  reg hsys_ff;
  reg nxt_hsys;
  reg hexe_ff;
  reg nxt_hexe;
  reg nxt_stack_we;
  reg [PCW-1:0] nxt_stack_wdata;
  reg nxt_acc_we;
  reg [7:0] nxt_acc_wdata;
  reg nxt_mem_we;
  reg [7:0] nxt_mem_wdata;
  reg nxt_flag_we;
  reg [3:0] nxt_flags;
  reg [3:0] flags_ff;
  reg nxt_chip_reset;
  reg nxt_wdt_clear;
  reg nxt_bubble;
  reg [7:0] nxt_rdata;
  reg [11:0] alu;
  reg skip;

  wire halted = hsys_ff | hexe_ff;
  wire issue = instr_valid_i & ~halted;
  wire exec = issue & (sq_ff == SQ_NONE);
  wire [PCW-1:0] pc_inc = pc_ff + {{(PCW-1){1'b0}}, 1'b1};
  wire wake = wake_i | (reg_we_i & (reg_addr_i == `SSC_REG_CTRL) & reg_wdata_i[`SSC_CTRL_WAKE]);
  wire do_sw_reset = exec & (instr_op_i == `SSC_OP_SW_RESET);

  always @* begin
    nxt_pc = pc_ff;
    nxt_stk = stk_ff;
    nxt_sq = sq_ff;
    nxt_gie = gie_ff;
    nxt_hsys = hsys_ff;
    nxt_hexe = hexe_ff;
    nxt_stack_we = 1'b0;
    nxt_stack_wdata = stack_wdata_o;
    nxt_acc_we = 1'b0;
    nxt_acc_wdata = acc_wdata_o;
    nxt_mem_we = 1'b0;
    nxt_mem_wdata = mem_wdata_o;
    nxt_flag_we = 1'b0;
    nxt_flags = flags_ff;
    nxt_chip_reset = 1'b0;
    nxt_wdt_clear = 1'b0;
    nxt_bubble = 1'b0;
    alu = 12'h000;
    skip = 1'b0;
    if (halted && wake) begin
      nxt_hsys = 1'b0;
      nxt_hexe = 1'b0;
    end
    if (issue && sq_ff != SQ_NONE) begin
      nxt_bubble = 1'b1;
      nxt_sq = SQ_NONE;
      if (sq_ff == SQ_SKIP) begin
        nxt_pc = pc_inc;
      end
    end
    if (exec) begin
      nxt_pc = pc_inc;
      case (instr_op_i)
        `SSC_OP_CEQ_MEM: begin
          alu = sub_flags(acc_i, operand_i);
          skip = alu[8];
          nxt_flag_we = 1'b1;
        end
        `SSC_OP_CEQ_IMM: begin
          alu = sub_flags(acc_i, imm_i);
          skip = alu[8];
          nxt_flag_we = 1'b1;
        end
        `SSC_OP_CNE_MEM: begin
          alu = sub_flags(acc_i, operand_i);
          skip = ~alu[8];
          nxt_flag_we = 1'b1;
        end
        `SSC_OP_CNE_IMM: begin
          alu = sub_flags(acc_i, imm_i);
          skip = ~alu[8];
          nxt_flag_we = 1'b1;
        end
        `SSC_OP_TEST_LOW: begin
          skip = ~operand_i[bit_sel_i];
        end
        `SSC_OP_TEST_HIGH: begin
          skip = operand_i[bit_sel_i];
        end
        `SSC_OP_INCZ_ACC: begin
          alu = add_flags(acc_i, 8'h01);
          skip = alu[8];
          nxt_flag_we = 1'b1;
          nxt_acc_we = 1'b1;
          nxt_acc_wdata = alu[7:0];
        end
        `SSC_OP_INCZ_MEM: begin
          alu = add_flags(operand_i, 8'h01);
          skip = alu[8];
          nxt_flag_we = 1'b1;
          nxt_mem_we = 1'b1;
          nxt_mem_wdata = alu[7:0];
        end
        `SSC_OP_DECZ_ACC: begin
          alu = sub_flags(acc_i, 8'h01);
          skip = alu[8];
          nxt_flag_we = 1'b1;
          nxt_acc_we = 1'b1;
          nxt_acc_wdata = alu[7:0];
        end
        `SSC_OP_DECZ_MEM: begin
          alu = sub_flags(operand_i, 8'h01);
          skip = alu[8];
          nxt_flag_we = 1'b1;
          nxt_mem_we = 1'b1;
          nxt_mem_wdata = alu[7:0];
        end
        `SSC_OP_CALL: begin
          nxt_stack_we = 1'b1;
          nxt_stack_wdata = pc_inc;
          nxt_pc = target_i;
          nxt_stk = stk_ff + `SSC_STACK_STEP;
          nxt_sq = SQ_FLUSH;
        end
        `SSC_OP_GOTO: begin
          nxt_pc = target_i;
          nxt_sq = SQ_FLUSH;
        end
        `SSC_OP_RET_IMM: begin
          nxt_acc_we = 1'b1;
          nxt_acc_wdata = imm_i;
          nxt_pc = stack_rdata_i;
          nxt_stk = stk_ff - `SSC_STACK_STEP;
          nxt_sq = SQ_FLUSH;
        end
        `SSC_OP_RET: begin
          nxt_pc = stack_rdata_i;
          nxt_stk = stk_ff - `SSC_STACK_STEP;
          nxt_sq = SQ_FLUSH;
        end
        `SSC_OP_RETI: begin
          nxt_pc = stack_rdata_i;
          nxt_stk = stk_ff - `SSC_STACK_STEP;
          nxt_sq = SQ_FLUSH;
          nxt_gie = 1'b1;
        end
        `SSC_OP_JUMP_ADD: begin
          nxt_pc = pc_ff + {{(PCW-8){1'b0}}, acc_i};
          nxt_sq = SQ_FLUSH;
        end
        `SSC_OP_INT_ON: begin
          nxt_gie = 1'b1;
        end
        `SSC_OP_INT_OFF: begin
          nxt_gie = 1'b0;
        end
        `SSC_OP_HALT_SYS: begin
          nxt_hsys = 1'b1;
        end
        `SSC_OP_HALT_EXE: begin
          nxt_hexe = 1'b1;
        end
        `SSC_OP_SW_RESET: begin
          nxt_chip_reset = 1'b1;
        end
        `SSC_OP_WDT_CLEAR: begin
          nxt_wdt_clear = 1'b1;
        end
        default: begin
          nxt_pc = pc_inc;
        end
      endcase
      if (skip) begin
        nxt_sq = SQ_SKIP;
      end
      if (nxt_flag_we) begin
        nxt_flags = alu[11:8];
      end
    end
  end

  always @* begin
    case (reg_addr_i)
      `SSC_REG_STATUS: nxt_rdata = {3'b000, sq_ff, gie_ff, hexe_ff, hsys_ff};
      `SSC_REG_PC_LOW: nxt_rdata = pc_ff[7:0];
      `SSC_REG_STACK: nxt_rdata = stk_ff;
      default: nxt_rdata = `SSC_RST_BYTE;
    endcase
    if (!reg_re_i) begin
      nxt_rdata = `SSC_RST_BYTE;
    end
  end

  always @(posedge clock_i) begin
    if (!rstn_i || do_sw_reset) begin
      pc_ff <= {PCW{1'b0}};
      stk_ff <= `SSC_RST_STACK;
      sq_ff <= SQ_NONE;
      gie_ff <= 1'b0;
      hsys_ff <= 1'b0;
      hexe_ff <= 1'b0;
      flags_ff <= 4'h0;
      stack_we_o <= 1'b0;
      stack_wdata_o <= {PCW{1'b0}};
      stack_addr_o <= `SSC_RST_STACK;
      acc_we_o <= 1'b0;
      acc_wdata_o <= `SSC_RST_BYTE;
      mem_we_o <= 1'b0;
      mem_wdata_o <= `SSC_RST_BYTE;
      flag_we_o <= 1'b0;
      wdt_clear_o <= 1'b0;
      bubble_o <= 1'b0;
      reg_rdata_o <= `SSC_RST_BYTE;
    end else begin
      pc_ff <= nxt_pc;
      stk_ff <= nxt_stk;
      sq_ff <= nxt_sq;
      gie_ff <= nxt_gie;
      hsys_ff <= nxt_hsys;
      hexe_ff <= nxt_hexe;
      flags_ff <= nxt_flags;
      stack_we_o <= nxt_stack_we;
      stack_wdata_o <= nxt_stack_wdata;
      stack_addr_o <= stk_ff;
      acc_we_o <= nxt_acc_we;
      acc_wdata_o <= nxt_acc_wdata;
      mem_we_o <= nxt_mem_we;
      mem_wdata_o <= nxt_mem_wdata;
      flag_we_o <= nxt_flag_we;
      wdt_clear_o <= nxt_wdt_clear;
      bubble_o <= nxt_bubble;
      reg_rdata_o <= nxt_rdata;
    end
  end

  // Software reset pulse is held outside the reset so it survives it.
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      chip_reset_o <= 1'b0;
    end else begin
      chip_reset_o <= nxt_chip_reset;
    end
  end

  always @* begin
    program_counter_o = pc_ff;
    stack_pointer_o = stk_ff;
    gie_o = gie_ff;
    clk_stop_o = hsys_ff | hexe_ff;
    osc_stop_o = hsys_ff;
    zero_flag_o = flags_ff[0];
    carry_flag_o = flags_ff[1];
    auxiliary_carry_flag_o = flags_ff[2];
    overflow_flag_o = flags_ff[3];
  end

endmodule

/* verilog/ssc_defs.vh */
// Constants for the skip and system-control execution unit.
// Assumes one clock domain and a plain register port of four addresses.
`ifndef SSC_DEFS_VH
`define SSC_DEFS_VH

// Instruction codes delivered by the core's decoder.
`define SSC_OP_W 5
`define SSC_OP_NOP 5'h00
`define SSC_OP_CEQ_MEM 5'h01
`define SSC_OP_CEQ_IMM 5'h02
`define SSC_OP_CNE_MEM 5'h03
`define SSC_OP_CNE_IMM 5'h04
`define SSC_OP_TEST_LOW 5'h05
`define SSC_OP_TEST_HIGH 5'h06
`define SSC_OP_INCZ_ACC 5'h07
`define SSC_OP_INCZ_MEM 5'h08
`define SSC_OP_DECZ_ACC 5'h09
`define SSC_OP_DECZ_MEM 5'h0A
`define SSC_OP_CALL 5'h0B
`define SSC_OP_GOTO 5'h0C
`define SSC_OP_RET_IMM 5'h0D
`define SSC_OP_RET 5'h0E
`define SSC_OP_RETI 5'h0F
`define SSC_OP_JUMP_ADD 5'h10
`define SSC_OP_INT_ON 5'h11
`define SSC_OP_INT_OFF 5'h12
`define SSC_OP_HALT_SYS 5'h13
`define SSC_OP_HALT_EXE 5'h14
`define SSC_OP_SW_RESET 5'h15
`define SSC_OP_WDT_CLEAR 5'h16

// Stack step per call or return, in bytes.
`define SSC_STACK_STEP 8'h02

// Register port addresses.
`define SSC_REG_AW 2
`define SSC_REG_CTRL 2'h0
`define SSC_REG_STATUS 2'h1
`define SSC_REG_PC_LOW 2'h2
`define SSC_REG_STACK 2'h3

// Field positions.
`define SSC_CTRL_WAKE 0
`define SSC_ST_HALT_SYS 0
`define SSC_ST_HALT_EXE 1
`define SSC_ST_GIE 2
`define SSC_ST_SQ_LO 3
`define SSC_ST_SQ_HI 4

// Reset values.
`define SSC_RST_BYTE 8'h00
`define SSC_RST_STACK 8'h00

`endif

/* dv/ssc_exec_monitor.sv */
// Concurrent checks for the skip and system-control execution unit.
// Bound into ssc_exec; sees only its ports, one clock, synchronous reset.
`include "ssc_defs.vh"
module ssc_exec_monitor #(
  parameter PCW = 12
) (
  // Clock, reset and instruction port.
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic instr_valid_i,
  input wire logic [4:0] instr_op_i,
  input wire logic [7:0] acc_i,
  input wire logic [7:0] imm_i,
  input wire logic [PCW-1:0] target_i,
  input wire logic [PCW-1:0] stack_rdata_i,
  // Observed results.
  input wire logic [PCW-1:0] program_counter_o,
  input wire logic [7:0] stack_pointer_o,
  input wire logic stack_we_o,
  input wire logic bubble_o,
  input wire logic acc_we_o,
  input wire logic [7:0] acc_wdata_o,
  input wire logic mem_we_o,
  input wire logic flag_we_o,
  input wire logic zero_flag_o,
  input wire logic gie_o,
  input wire logic clk_stop_o,
  input wire logic osc_stop_o,
  input wire logic wdt_clear_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  // Opcode of an accepted instruction, an unused code otherwise.
  logic [4:0] op;
  assign op = (instr_valid_i && !clk_stop_o) ? instr_op_i : 5'h1F;

  AST_CALL: assert property (op == `SSC_OP_CALL |=> bubble_o ||
    (stack_we_o && program_counter_o == $past(target_i) &&
    stack_pointer_o == $past(stack_pointer_o) + 8'h02)) else $error("call effect wrong");
  AST_RET: assert property (op == `SSC_OP_RET |=> bubble_o ||
    (program_counter_o == $past(stack_rdata_i) &&
    stack_pointer_o == $past(stack_pointer_o) - 8'h02)) else $error("return effect wrong");
  AST_GOTO: assert property (op == `SSC_OP_GOTO |=> bubble_o ||
    (program_counter_o == $past(target_i) && !flag_we_o)) else $error("goto wrong");
  AST_NOP: assert property (op == `SSC_OP_NOP |=>
    !(stack_we_o || acc_we_o || mem_we_o || flag_we_o) && $stable(stack_pointer_o) &&
    $stable(gie_o)) else $error("nop changed state");
  AST_CEQ_IMM: assert property (op == `SSC_OP_CEQ_IMM && acc_i == imm_i |=>
    bubble_o || (flag_we_o && zero_flag_o)) else $error("compare equal flags wrong");
  AST_TEST_FLAGS: assert property (op == `SSC_OP_TEST_LOW ||
    op == `SSC_OP_TEST_HIGH |=> !flag_we_o) else $error("bit test wrote flags");
  AST_INC_ACC: assert property (op == `SSC_OP_INCZ_ACC |=> bubble_o ||
    (acc_we_o && acc_wdata_o == $past(acc_i) + 8'h01)) else $error("increment wrong");
  AST_RETI: assert property (op == `SSC_OP_RETI |=> bubble_o || gie_o)
    else $error("interrupt return left enable low");
  AST_WDT: assert property (op == `SSC_OP_WDT_CLEAR |=> bubble_o || wdt_clear_o)
    else $error("watchdog clear missing");
  AST_HALT_EXE: assert property (op == `SSC_OP_HALT_EXE |=> bubble_o ||
    (clk_stop_o && !osc_stop_o)) else $error("execution halt wrong");
  AST_HALT_SYS: assert property (op == `SSC_OP_HALT_SYS |=> bubble_o ||
    (clk_stop_o && osc_stop_o)) else $error("full halt wrong");
  AST_BUBBLE: assert property (bubble_o |->
    !(stack_we_o || acc_we_o || mem_we_o || flag_we_o || wdt_clear_o))
    else $error("bubble had side effects");

  cover property (op == `SSC_OP_CALL);
  cover property (bubble_o);
  cover property (clk_stop_o && osc_stop_o);
endmodule

bind ssc_exec ssc_exec_monitor #(.PCW(PCW)) ssc_exec_monitor_inst (.*);

/* dv/tb_ssc_exec.sv */
// Self-checking bench for the skip and system-control execution unit.
// Drives every input itself at the rising edge; no far-side model.
`include "ssc_defs.vh"
module tb_ssc_exec;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i, rstn_i, reg_we_i, reg_re_i, instr_valid_i, wake_i;
  logic [1:0] reg_addr_i;
  logic [7:0] reg_wdata_i, operand_i, acc_i, imm_i, reg_rdata_o, stack_pointer_o;
  logic [7:0] stack_addr_o, acc_wdata_o, mem_wdata_o, a_v, m_v;
  logic [4:0] instr_op_i;
  logic [2:0] bit_sel_i, b_v;
  logic [11:0] target_i, stack_rdata_i, program_counter_o, stack_wdata_o, t_v;
  logic stack_we_o, bubble_o, acc_we_o, mem_we_o, flag_we_o, zero_flag_o, carry_flag_o;
  logic auxiliary_carry_flag_o, overflow_flag_o, gie_o, clk_stop_o, osc_stop_o;
  logic chip_reset_o, wdt_clear_o;
  int failures, checked, cyc, i;
  logic [4:0] cmp [4] = '{`SSC_OP_CEQ_MEM, `SSC_OP_CEQ_IMM, `SSC_OP_CNE_MEM, `SSC_OP_CNE_IMM};
  logic [4:0] idz [4] = '{`SSC_OP_INCZ_ACC, `SSC_OP_DECZ_ACC, `SSC_OP_INCZ_MEM, `SSC_OP_DECZ_MEM};
  logic [7:0] res [4] = '{8'h00, 8'hFF, 8'h06, 8'h00};
  logic [4:0] rets [3] = '{`SSC_OP_RET_IMM, `SSC_OP_RET, `SSC_OP_RETI};

  ssc_exec #(.PCW(12)) ssc_exec_inst (.*);

  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Presents one instruction with the current operands, then idles.
  task automatic run(input logic [4:0] op);
    @(posedge clock_i);
    instr_valid_i <= 1'b1;
    instr_op_i <= op;
    acc_i <= a_v;
    operand_i <= m_v;
    imm_i <= m_v;
    bit_sel_i <= b_v;
    target_i <= t_v;
    stack_rdata_i <= t_v;
    @(posedge clock_i);
    instr_valid_i <= 1'b0;
    @(negedge clock_i);
  endtask

  task automatic nxt(input logic skip);
    run(`SSC_OP_NOP);
    chk(bubble_o, skip);
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge clock_i);
    reg_re_i <= 1'b0;
    @(negedge clock_i);
    chk(reg_rdata_o, exp);
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    @(posedge clock_i);
    reg_we_i <= 1'b0;
    @(negedge clock_i);
  endtask

  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      conclude();
    end
  end

  initial begin
    {rstn_i, reg_we_i, reg_re_i, instr_valid_i, wake_i, reg_addr_i, reg_wdata_i} = '0;
    {operand_i, acc_i, imm_i, instr_op_i, bit_sel_i, target_i, stack_rdata_i} = '0;
    {a_v, m_v, b_v, t_v} = '0;
    repeat (4) @(posedge clock_i);
    rstn_i <= 1'b1;
    @(negedge clock_i);
    chk(program_counter_o, 12'h000);
    rd(`SSC_REG_STATUS, 8'h00);
    t_v = 12'h100;
    run(`SSC_OP_GOTO);
    chk(program_counter_o, 12'h100);
    nxt(1'b1);
    a_v = 8'h10;
    for (i = 0; i < 8; i++) begin
      m_v = i[0] ? 8'h20 : 8'h10;
      run(cmp[i / 2]);
      chk(zero_flag_o, !i[0]);
      chk(carry_flag_o, i[0]);
      nxt((i < 4) ^ i[0]);
    end
    m_v = 8'h20;
    for (i = 0; i < 4; i++) begin
      b_v = i[0] ? 3'h4 : 3'h5;
      run(i[1] ? `SSC_OP_TEST_HIGH : `SSC_OP_TEST_LOW);
      chk(flag_we_o, 1'b0);
      nxt(i[1] ^ i[0]);
    end
    b_v = 3'h5;
    run(`SSC_OP_TEST_HIGH);
    run(`SSC_OP_WDT_CLEAR);
    chk(wdt_clear_o, 1'b0);
    chk(bubble_o, 1'b1);
    for (i = 0; i < 4; i++) begin
      a_v = i[0] ? 8'h00 : 8'hFF;
      m_v = i[0] ? 8'h01 : 8'h05;
      run(idz[i]);
      chk(i < 2 ? acc_wdata_o : mem_wdata_o, res[i]);
      chk(zero_flag_o, res[i] == 8'h00);
      chk(auxiliary_carry_flag_o, i < 2);
      chk(i < 2 ? acc_we_o : mem_we_o, 1'b1);
      nxt(res[i] == 8'h00);
    end
    a_v = 8'h80;
    m_v = 8'h01;
    run(`SSC_OP_CEQ_MEM);
    chk(overflow_flag_o, 1'b1);
    chk(auxiliary_carry_flag_o, 1'b1);
    nxt(1'b0);
    t_v = 12'h200;
    run(`SSC_OP_GOTO);
    nxt(1'b1);
    t_v = 12'h300;
    for (i = 0; i < 3; i++) begin
      run(`SSC_OP_CALL);
      chk(stack_addr_o, 2 * i);
      chk(stack_wdata_o, i ? 12'h301 : 12'h201);
      chk(stack_pointer_o, 2 * i + 2);
      chk(stack_we_o, 1'b1);
      nxt(1'b1);
    end
    wr(`SSC_REG_STACK, 8'hAA);
    rd(`SSC_REG_STACK, 8'h06);
    m_v = 8'h55;
    t_v = 12'h0A5;
    for (i = 0; i < 3; i++) begin
      run(rets[i]);
      chk(stack_pointer_o, 4 - 2 * i);
      chk(program_counter_o, t_v);
      if (i == 0) chk(acc_wdata_o, 8'h55);
      chk(acc_we_o, i == 0);
      nxt(1'b1);
    end
    chk(gie_o, 1'b1);
    t_v = 12'h080;
    run(`SSC_OP_GOTO);
    nxt(1'b1);
    a_v = 8'h10;
    run(`SSC_OP_JUMP_ADD);
    chk(program_counter_o, 12'h090);
    nxt(1'b1);
    rd(`SSC_REG_PC_LOW, 8'h90);
    run(`SSC_OP_INT_OFF);
    chk(gie_o, 1'b0);
    run(`SSC_OP_INT_ON);
    chk(gie_o, 1'b1);
    run(`SSC_OP_WDT_CLEAR);
    chk(wdt_clear_o, 1'b1);
    run(`SSC_OP_HALT_EXE);
    chk(osc_stop_o, 1'b0);
    rd(`SSC_REG_STATUS, 8'h06);
    run(`SSC_OP_INT_OFF);
    chk(gie_o, 1'b1);
    wr(`SSC_REG_CTRL, 8'h01);
    chk(clk_stop_o, 1'b0);
    run(`SSC_OP_HALT_SYS);
    chk(osc_stop_o, 1'b1);
    @(posedge clock_i);
    wake_i <= 1'b1;
    @(posedge clock_i);
    wake_i <= 1'b0;
    @(negedge clock_i);
    chk(clk_stop_o, 1'b0);
    run(`SSC_OP_SW_RESET);
    chk(chip_reset_o, 1'b1);
    chk(gie_o, 1'b0);
    chk(program_counter_o, 12'h000);
    conclude();
  end
endmodule
